// ### common/touch_sense_pkg.sv
// Package for the touch sensing control block: register map, field
// layout, reset values, state and carrier types.
// Assumes a 32-bit register port and a single 20 MHz clock.
package touch_sense_pkg;

    // ==========================================================
    // Bus and register map
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 32;
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_IRQ_ST  = 8'h04;
    localparam logic [7:0]  OFS_IRQ_MSK = 8'h08;
    localparam logic [7:0]  OFS_STATUS  = 8'h0C;

    // ==========================================================
    // Control register fields
    localparam int          GO_BIT      = 0;
    localparam int          TRIG_BIT    = 1;
    localparam int          SNZ_BIT     = 2;
    localparam int          INIT_BIT    = 4;
    localparam int          TXV_LSB     = 6;
    localparam int          PWR_BIT     = 8;
    localparam int          LPF_BIT     = 9;
    localparam int          LV_BIT      = 10;
    localparam int          MODE_LSB    = 14;
    localparam int          NCH_LSB     = 16;
    localparam int          NCH_W       = 5;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    // Go and init are handled apart; the rest store as written
    localparam logic [31:0] CTRL_WMASK  = 32'h001F_C7C6;

    // Transmit supply codes
    localparam logic [1:0]  TXV_IO      = 2'h0;
    localparam logic [1:0]  TXV_VCC_A   = 2'h1;
    localparam logic [1:0]  TXV_LOGIC   = 2'h2;
    localparam logic [1:0]  TXV_VCC_B   = 2'h3;

    // Measurement mode codes: high bit mutual, low bit multi scan
    localparam int          MODE_MUTUAL = 1;
    localparam int          MODE_MULTI  = 0;

    // ==========================================================
    // Interrupt status and mask bits
    localparam int          IRQ_W       = 4;
    localparam int          IRQ_SETREQ  = 0;
    localparam int          IRQ_RDREQ   = 1;
    localparam int          IRQ_END     = 2;
    localparam int          IRQ_NOTOUCH = 3;
    localparam logic [3:0]  IRQ_RESET   = 4'h0;

    // Status register fields
    localparam int          ST_BUSY_BIT = 0;
    localparam int          ST_CH_LSB   = 8;

    // ==========================================================
    // Timing
    localparam int          CLK_NS      = 50;
    localparam int          MEAS_NS     = 1600;
    localparam int          MEAS_CYC    = (MEAS_NS + CLK_NS - 1) / CLK_NS;

    // ==========================================================
    // Types
    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_SETREQ = 5'b00010,
        ST_MEAS   = 5'b00100,
        ST_RDREQ  = 5'b01000,
        ST_DONE   = 5'b10000
    } seq_state_t;

    typedef enum logic [2:0] {
        SUP_IO    = 3'b001,
        SUP_VCC   = 3'b010,
        SUP_LOGIC = 3'b100
    } tx_supply_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bus_req_t;

    typedef struct packed {
        logic       measure_power_enable;
        logic       filter_cap_charge_control;
        logic       supply_operating_mode;
        tx_supply_t transmit_supply;
        logic       mutual;
        logic       multi_scan;
        logic       measuring;
        logic [NCH_W-1:0] channel;
    } analog_ctrl_t;

endpackage : touch_sense_pkg

// ### design/touch_sense_control.sv
// Control logic of the capacitive touch sensing unit: register port,
// start selection, channel sequencing, interrupts and snooze wake.
// Assumes event, snooze and judge inputs come from logic on clk.
//
// Operation
// - Software go bit starts when software trigger
// - Trigger select picks software or external start
// - External mode starts on event linker pulse
// - Snooze enable allows event-started snooze measurements
// - Measurement end interrupt can end snooze
// - Non-touch judgement can end snooze
// - Init bit reinitializes measurement control
// - Main control fields in one 32-bit register
// - Transmit supply select decodes IO, VCC, logic, VCC
// - Bit 9 controls filter capacitor charging
// - Bits 15:14 select self/mutual, single/multi
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/100ps
module touch_sense_control #(
    parameter int MEAS_CYCLES    = touch_sense_pkg::MEAS_CYC,
    parameter bit HAS_AUTO_JUDGE = 1'b1
) (
    input  wire logic                           clk,
    input  wire logic                           reset_n,
    input  wire touch_sense_pkg::bus_req_t      bus,
    output      logic [touch_sense_pkg::DATA_W-1:0] rdata,
    input  wire logic                           link_event,
    input  wire logic                           snooze_active,
    input  wire logic                           non_touch_detect,
    output      touch_sense_pkg::analog_ctrl_t  analog,
    output      logic                           irq,
    output      logic                           snooze_wake
);
    import touch_sense_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic ctl_bit(input logic [31:0] v, input int b);
        ctl_bit = v[b];
    endfunction : ctl_bit

    function automatic logic [1:0] ctl_pair(input logic [31:0] v,
                                            input int lsb);
        ctl_pair = v[lsb +: 2];
    endfunction : ctl_pair

    function automatic logic seq_idle(input seq_state_t s);
        seq_idle = (s == ST_IDLE);
    endfunction : seq_idle

    function automatic logic [NCH_W-1:0] last_index(input logic [31:0] v);
        last_index = v[NCH_LSB +: NCH_W];
    endfunction : last_index

    // ==========================================================
    // Reset release
    // Assert at once, release two edges late to dodge metastability
    logic rst_meta_q;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n <= rst_meta_q;
        end
    end

    // ==========================================================
    // Register port decode
    // Unmapped offsets decode to nothing and are ignored
    logic wr_ctrl;
    logic wr_ist;
    logic wr_msk;

    assign wr_ctrl = bus.wr && (bus.addr == OFS_CTRL);
    assign wr_ist  = bus.wr && (bus.addr == OFS_IRQ_ST);
    assign wr_msk  = bus.wr && (bus.addr == OFS_IRQ_MSK);

    // ==========================================================
    // Sequencer and register state
    localparam int CNT_W = $clog2(MEAS_CYCLES + 1);

    seq_state_t         state_q, state_d;
    logic [31:0]        ctrl_q, ctrl_d;
    logic               go_q, go_d;
    logic [NCH_W-1:0]   ch_q, ch_d;
    logic [CNT_W-1:0]   cnt_q, cnt_d;
    logic [IRQ_W-1:0]   ist_q, ist_d;
    logic [IRQ_W-1:0]   msk_q, msk_d;
    logic [IRQ_W-1:0]   ev_set;
    logic               wake_q, wake_d;
    logic [DATA_W-1:0]  rdata_q, rdata_d;
    analog_ctrl_t       analog_q, analog_d;
    logic               init_req;
    logic               sw_start;
    logic               ext_start;
    logic               start;
    logic               multi;
    logic               last_ch;

    // Init strobe is self clearing and never stored
    assign init_req = wr_ctrl && bus.wdata[INIT_BIT];

    // Whole-word write; strobe and read-only bits masked off
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = bus.wdata & CTRL_WMASK;
        end
    end

    // Start selection; in snooze only the event linker may start,
    // since no software runs to write the go bit there
    always_comb begin
        sw_start  = wr_ctrl && bus.wdata[GO_BIT]
                    && !ctl_bit(ctrl_d, TRIG_BIT)
                    && !snooze_active;
        ext_start = link_event && ctl_bit(ctrl_q, TRIG_BIT)
                    && (!snooze_active
                        || ctl_bit(ctrl_q, SNZ_BIT));
        start     = (sw_start || ext_start) && !init_req
                    && seq_idle(state_q);
    end

    assign multi   = ctl_bit(ctrl_q, MODE_LSB + MODE_MULTI);
    assign last_ch = !multi
                     || (ch_q == last_index(ctrl_q));

    always_comb begin
        state_d = state_q;
        go_d    = go_q;
        ch_d    = ch_q;
        cnt_d   = cnt_q;
        ev_set  = '0;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    state_d = ST_SETREQ;
                    go_d    = 1'b1;
                    ch_d    = '0;
                end
            end
            ST_SETREQ: begin
                // Reload per channel so each gets the full window
                ev_set[IRQ_SETREQ] = 1'b1;
                cnt_d   = CNT_W'(MEAS_CYCLES - 1);
                state_d = ST_MEAS;
            end
            ST_MEAS: begin
                if (cnt_q == '0) begin
                    state_d = ST_RDREQ;
                end else begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
            ST_RDREQ: begin
                ev_set[IRQ_RDREQ] = 1'b1;
                if (last_ch) begin
                    state_d = ST_DONE;
                end else begin
                    ch_d    = ch_q + NCH_W'(1);
                    state_d = ST_SETREQ;
                end
            end
            ST_DONE: begin
                ev_set[IRQ_END] = 1'b1;
                go_d    = 1'b0;
                state_d = ST_IDLE;
            end
            default: begin
                // Illegal codes fall back to idle
                state_d = ST_IDLE;
                go_d    = 1'b0;
            end
        endcase
        ev_set[IRQ_NOTOUCH] = HAS_AUTO_JUDGE && non_touch_detect;
        // Init last, so it beats any start in the same cycle
        if (init_req) begin
            state_d = ST_IDLE;
            go_d    = 1'b0;
            ch_d    = '0;
            cnt_d   = '0;
        end
    end

    // ==========================================================
    // Interrupts: set wins over a write-one clear in the same cycle
    always_comb begin
        ist_d = ist_q;
        msk_d = msk_q;
        if (wr_ist) begin
            ist_d = ist_q & ~bus.wdata[IRQ_W-1:0];
        end
        ist_d = ist_d | ev_set;
        if (wr_msk) begin
            msk_d = bus.wdata[IRQ_W-1:0];
        end
    end

    // Level output, straight from registered status and mask
    assign irq = |(ist_q & msk_q);

    // ==========================================================
    // Snooze wake, held until the system leaves snooze
    // Needs the mask bit, so a masked source never breaks snooze
    always_comb begin
        wake_d = wake_q;
        if (!snooze_active) begin
            wake_d = 1'b0;
        end else if (ctl_bit(ctrl_q, SNZ_BIT)) begin
            if (ev_set[IRQ_END] && msk_q[IRQ_END]) begin
                wake_d = 1'b1;
            end
            if (ev_set[IRQ_NOTOUCH] && msk_q[IRQ_NOTOUCH]) begin
                wake_d = 1'b1;
            end
        end
    end

    // ==========================================================
    // Analog side controls
    // Registered so the analog side never sees decode glitches
    always_comb begin
        analog_d = '0;
        analog_d.measure_power_enable      = ctl_bit(ctrl_q, PWR_BIT);
        analog_d.filter_cap_charge_control = ctl_bit(ctrl_q, LPF_BIT);
        // Stored only; software owns the low-voltage setting
        analog_d.supply_operating_mode     = ctl_bit(ctrl_q, LV_BIT);
        case (ctl_pair(ctrl_q, TXV_LSB))
            TXV_IO:    analog_d.transmit_supply = SUP_IO;
            TXV_VCC_A: analog_d.transmit_supply = SUP_VCC;
            TXV_LOGIC: analog_d.transmit_supply = SUP_LOGIC;
            TXV_VCC_B: analog_d.transmit_supply = SUP_VCC;
            default:   analog_d.transmit_supply = SUP_IO;
        endcase
        analog_d.mutual     = ctl_bit(ctrl_q, MODE_LSB + MODE_MUTUAL);
        analog_d.multi_scan = multi;
        analog_d.measuring  = (state_q == ST_MEAS);
        analog_d.channel    = ch_q;
    end

    // ==========================================================
    // Read data, one cycle after the strobe
    // Zero outside the answer cycle, so stale words never look fresh
    always_comb begin
        rdata_d = '0;
        if (bus.rd) begin
            case (bus.addr)
                OFS_CTRL: begin
                    rdata_d         = ctrl_q;
                    rdata_d[GO_BIT] = go_q;
                end
                OFS_IRQ_ST:  rdata_d[IRQ_W-1:0] = ist_q;
                OFS_IRQ_MSK: rdata_d[IRQ_W-1:0] = msk_q;
                OFS_STATUS: begin
                    rdata_d[ST_BUSY_BIT]         = !seq_idle(state_q);
                    rdata_d[ST_CH_LSB +: NCH_W]  = ch_q;
                end
                default: rdata_d = '0;
            endcase
        end
    end

    assign rdata       = rdata_q;
    assign analog      = analog_q;
    assign snooze_wake = wake_q;

    // ==========================================================
    // State registers
    // One block; every flop leaves reset on the synchronised copy
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_q  <= ST_IDLE;
            ctrl_q   <= CTRL_RESET;
            go_q     <= 1'b0;
            ch_q     <= '0;
            cnt_q    <= '0;
            ist_q    <= IRQ_RESET;
            msk_q    <= IRQ_RESET;
            wake_q   <= 1'b0;
            rdata_q  <= '0;
            analog_q <= '{default: '0, transmit_supply: SUP_IO};
        end else begin
            state_q  <= state_d;
            ctrl_q   <= ctrl_d;
            go_q     <= go_d;
            ch_q     <= ch_d;
            cnt_q    <= cnt_d;
            ist_q    <= ist_d;
            msk_q    <= msk_d;
            wake_q   <= wake_d;
            rdata_q  <= rdata_d;
            analog_q <= analog_d;
        end
    end

endmodule : touch_sense_control

// ### tb/event_link_model.sv
// Event linker stand-in: one-cycle start pulse after a chosen lag.
// Assumes fire is a one-cycle request on clk.
`timescale 1ns/100ps
module event_link_model (
    input  wire logic       clk,
    input  wire logic       fire,
    input  wire logic [3:0] lag,
    output      logic       link_event
);
    logic [4:0] cnt_q = 5'h00;
    initial link_event = 1'b0;
    always @(posedge clk) begin
        link_event <= cnt_q == 5'h01;
        cnt_q      <= fire ? {1'b0, lag} + 5'h01 :
                      (cnt_q != 5'h00 ? cnt_q - 5'h01 : 5'h00);
    end
endmodule : event_link_model

// ### tb/touch_sense_control_checker.sv
// Checker: port-level timing of the touch sensing control block.
// Assumes it is bound into touch_sense_control; one clock domain.
`timescale 1ns/100ps
module touch_sense_checker #(
    parameter int MEAS_CYCLES = touch_sense_pkg::MEAS_CYC
) (
    input wire logic                               clk,
    input wire logic                               reset_n,
    input wire touch_sense_pkg::bus_req_t          bus,
    input wire logic [touch_sense_pkg::DATA_W-1:0] rdata,
    input wire logic                               snooze_active,
    input wire touch_sense_pkg::analog_ctrl_t      analog,
    input wire logic                               irq,
    input wire logic                               snooze_wake
);
    import touch_sense_pkg::*;
    // ========================================
    // Helpers
    logic ctrl_wr;
    int   run_q;
    int   run_d;
    logic init_q;
    logic init_d;
    assign ctrl_wr = bus.wr && bus.addr == OFS_CTRL;
    always_comb begin
        run_d  = analog.measuring ? run_q + 1 : 0;
        // Abort by init shortens a phase legally
        init_d = (ctrl_wr && bus.wdata[INIT_BIT]) ||
                 (init_q && analog.measuring);
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            run_q  <= 0;
            init_q <= 1'b0;
        end else begin
            run_q  <= run_d;
            init_q <= init_d;
        end
    end
    function automatic tx_supply_t sup_f(input logic [1:0] c);
        return c == 2'h0 ? SUP_IO : (c == 2'h2 ? SUP_LOGIC : SUP_VCC);
    endfunction : sup_f
    // ========================================
    // Properties
    default clocking dc @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence ctrl_wr_s;
        ctrl_wr;
    endsequence
    sequence settle_s;
        ctrl_wr_s ##2 1'b1;
    endsequence
    rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == '0)
        else $error("read data outside answer cycle");
    power_bit_a: assert property (settle_s |->
        analog.measure_power_enable == $past(bus.wdata[PWR_BIT], 2))
        else $error("power enable not bit 8");
    filter_bit_a: assert property (settle_s |->
        analog.filter_cap_charge_control == $past(bus.wdata[LPF_BIT], 2))
        else $error("filter charge not bit 9");
    tx_decode_a: assert property (settle_s |->
        analog.transmit_supply == sup_f($past(bus.wdata[TXV_LSB+:2], 2)))
        else $error("transmit supply decode wrong");
    mode_field_a: assert property (settle_s |->
        {analog.mutual, analog.multi_scan} ==
        $past(bus.wdata[MODE_LSB+:2], 2))
        else $error("mode field wrong");
    init_abort_a: assert property ((ctrl_wr_s ##0 bus.wdata[INIT_BIT])
        |-> ##2 (!analog.measuring)[*2])
        else $error("measuring after init");
    meas_len_a: assert property ($fell(analog.measuring) |->
        run_q == MEAS_CYCLES || init_q)
        else $error("measure phase length wrong");
    wake_drop_a: assert property ($fell(snooze_active) |->
        ##1 !snooze_wake)
        else $error("wake held after snooze left");
    wake_cause_a: assert property ($rose(snooze_wake) |->
        $past(snooze_active) ##[0:1] irq)
        else $error("wake without snooze or irq");
endmodule : touch_sense_checker

bind touch_sense_control touch_sense_checker #(
    .MEAS_CYCLES(MEAS_CYCLES)
) touch_sense_checker_i (
    .clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
    .snooze_active(snooze_active), .analog(analog), .irq(irq),
    .snooze_wake(snooze_wake)
);

// ### tb/touch_sense_control_tb.sv
// Self-checking bench of the touch sensing control block.
// Assumes the checker binds itself; drives change on rising edges.
`timescale 1ns/100ps
module touch_sense_control_tb;
    import touch_sense_pkg::*;
    typedef struct packed {
        logic [31:0] w;
        tx_supply_t  tx;
    } row_t;
    logic              clk = 1'b0;
    logic              reset_n = 1'b0;
    bus_req_t          bus = '0;
    logic [DATA_W-1:0] rdata;
    logic              link_event;
    logic              snooze_active = 1'b0;
    logic              non_touch_detect = 1'b0;
    logic              fire = 1'b0;
    logic [3:0]        lag = 4'h0;
    analog_ctrl_t      analog;
    logic              irq;
    logic              snooze_wake;
    int                err_count = 0;
    int                samples_checked = 0;
    int                cycles = 0;
    int                rises = 0;
    row_t rows [4] = '{'{32'h0000_0100, SUP_IO}, '{32'h0000_8240, SUP_VCC},
        '{32'h0000_4480, SUP_LOGIC}, '{32'h0000_C7C0, SUP_VCC}};

    touch_sense_control #(.MEAS_CYCLES(4)) touch_sense_control_i (
        .clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
        .link_event(link_event), .snooze_active(snooze_active),
        .non_touch_detect(non_touch_detect), .analog(analog), .irq(irq),
        .snooze_wake(snooze_wake));
    event_link_model event_link_model_i (.clk(clk), .fire(fire),
        .lag(lag), .link_event(link_event));

    always #25 clk = ~clk;
    always @(posedge analog.measuring) rises++;
    // Whole run is a few hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            test_done();
        end
    end
    // ========================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hFFFF_FFFF);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        chk(rdata & m, e);
        @(posedge clk);
    endtask : rd
    task automatic pulse(input logic [3:0] l);
        fire <= 1'b1;
        lag  <= l;
        @(posedge clk);
        fire <= 1'b0;
    endtask : pulse
    task automatic wait_irq();
        int n = 0;
        while (irq !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        chk(irq, 1'b1);
    endtask : wait_irq
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    // ========================================
    // Sequence
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(OFS_CTRL, CTRL_RESET);
        rd(8'h10, 32'h0);
        foreach (rows[i]) begin
            wr(OFS_CTRL, rows[i].w);
            rd(OFS_CTRL, rows[i].w);
            chk(analog.transmit_supply, rows[i].tx);
            chk({analog.measure_power_enable, analog.mutual,
                 analog.multi_scan}, {rows[i].w[8], rows[i].w[15:14]});
            chk({analog.supply_operating_mode,
                 analog.filter_cap_charge_control}, rows[i].w[10:9]);
            $display("row %0d done", i);
        end
        wr(OFS_IRQ_MSK, 32'h4);
        wr(OFS_CTRL, 32'h1);
        rd(OFS_CTRL, 32'h1, 32'h1);
        rd(OFS_STATUS, 32'h1);
        wait_irq();
        rd(OFS_IRQ_ST, 32'h7);
        rd(OFS_CTRL, 32'h0, 32'h1);
        wr(OFS_IRQ_ST, 32'hF);
        chk(irq, 1'b0);
        $display("software start done");
        rises = 0;
        wr(OFS_CTRL, 32'h0002_4001);
        wait_irq();
        chk(rises, 3);
        chk(analog.channel, 32'h2);
        rd(OFS_STATUS, 32'h0000_0200);
        wr(OFS_IRQ_ST, 32'hF);
        $display("multi scan done");
        wr(OFS_CTRL, 32'h3);
        rd(OFS_CTRL, 32'h2);
        pulse(4'h5);
        wait_irq();
        wr(OFS_IRQ_ST, 32'hF);
        wr(OFS_CTRL, 32'h0);
        pulse(4'h0);
        repeat (20) @(posedge clk);
        rd(OFS_IRQ_ST, 32'h0);
        $display("trigger select done");
        snooze_active <= 1'b1;
        wr(OFS_CTRL, 32'h2);
        pulse(4'h0);
        repeat (20) @(posedge clk);
        rd(OFS_IRQ_ST, 32'h0);
        wr(OFS_CTRL, 32'h6);
        pulse(4'h2);
        wait_irq();
        chk(snooze_wake, 1'b1);
        snooze_active <= 1'b0;
        repeat (2) @(posedge clk);
        chk(snooze_wake, 1'b0);
        wr(OFS_IRQ_ST, 32'hF);
        wr(OFS_IRQ_MSK, 32'h8);
        snooze_active    <= 1'b1;
        non_touch_detect <= 1'b1;
        @(posedge clk);
        non_touch_detect <= 1'b0;
        wait_irq();
        chk(snooze_wake, 1'b1);
        snooze_active <= 1'b0;
        wr(OFS_IRQ_ST, 32'hF);
        $display("snooze done");
        wr(OFS_IRQ_MSK, 32'h4);
        wr(OFS_CTRL, 32'h1);
        wr(OFS_CTRL, 32'h10);
        rd(OFS_CTRL, 32'h0);
        repeat (20) @(posedge clk);
        chk(irq, 1'b0);
        wr(OFS_CTRL, 32'h0000_8101);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(OFS_CTRL, CTRL_RESET);
        $display("init and reset done");
        test_done();
    end
endmodule : touch_sense_control_tb
